// *** rtl/ddsl_pkg.sv ***
// shared constants and types for the dual converter serial load block
package ddsl_pkg;
  // serial frame layout
  localparam int          FRAME_W   = 16;
  localparam int          CODE_W    = 12;
  localparam int          NUM_CH    = 2;
  localparam int          MODE_HI   = 15;
  localparam int          MODE_LO   = 14;
  localparam int          TERM_HI   = 13;
  localparam int          TERM_LO   = 12;
  localparam int          SEL_BIT   = 12;
  localparam logic [4:0]  CNT_LAST  = 5'h0F;
  localparam logic [4:0]  CNT_ZERO  = 5'h00;
  localparam logic [4:0]  CNT_ONE   = 5'h01;

  // operating mode field encodings
  localparam logic [1:0]  MODE_ONE  = 2'h0;
  localparam logic [1:0]  MODE_BOTH = 2'h1;
  localparam logic [1:0]  MODE_PD   = 2'h2;

  // power-down termination, zero means powered up
  localparam logic [1:0]  TERM_AWAKE = 2'h0;

  localparam int          FIFO_DEPTH = 8;

  // register map, byte addresses
  localparam int          ADDR_W    = 5;
  localparam logic [4:0]  OFS_CTRL  = 5'h00;
  localparam logic [4:0]  OFS_STAT  = 5'h04;
  localparam logic [4:0]  OFS_CODES = 5'h08;
  localparam logic [4:0]  OFS_FRMS  = 5'h0C;
  localparam logic [4:0]  OFS_ABRT  = 5'h10;

  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_HOLD_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  localparam int          STAT_LVL_LO   = 0;
  localparam int          STAT_PD_BIT   = 4;
  localparam int          STAT_OVR_BIT  = 5;
  localparam int          CODEB_LO      = 16;
  localparam logic [15:0] CNT16_ONE     = 16'h0001;

  typedef enum logic [1:0] {
    LK_IDLE,
    LK_SHIFT,
    LK_FULL
  } ddsl_link_t;
endpackage : ddsl_pkg

// *** rtl/ddsl_fifo_if.sv ***
// stream carrier between frame receiver and frame buffer
`timescale 1ns/1ps
interface ddsl_fifo_if #(
  parameter int WIDTH = 16,
  parameter int LVL_W = 4
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic [LVL_W-1:0] level;

  modport buf_side (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, level
  );
  modport user_side (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data, level
  );
endinterface : ddsl_fifo_if

// *** rtl/ddsl_fifo.sv ***
// frame buffer with valid/ready on both sides
`timescale 1ns/1ps
module ddsl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  input  wire logic  mclk_i,
  input  wire logic  rstn_i,
  ddsl_fifo_if.buf_side f
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [LVL_W-1:0] cnt_ff;
  wire              full  = (cnt_ff == LVL_W'(DEPTH));
  wire              empty = (cnt_ff == '0);
  wire              wr_en = f.push_valid & ~full;
  wire              rd_en = f.pop_ready & ~empty;

  // full refuses pushes honestly so the source sees back-pressure
  assign f.push_ready = ~full;
  assign f.pop_valid  = ~empty;
  assign f.pop_data   = mem[rd_ptr_ff];
  assign f.level      = cnt_ff;

  // storage has no reset, only pointers and count carry state
  always_ff @(posedge mclk_i) begin
    if (wr_en) begin
      mem[wr_ptr_ff] <= f.push_data;
    end
  end

  // pointers wrap on the power-of-two depth
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      wr_ptr_ff <= wr_en ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      rd_ptr_ff <= rd_en ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      cnt_ff    <= cnt_ff + LVL_W'(wr_en) - LVL_W'(rd_en);
    end
  end
endmodule : ddsl_fifo

// *** rtl/ddsl_top.sv ***
// serial load, frame buffer and update logic of the dual converter
`timescale 1ns/1ps
module ddsl_top
  import ddsl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              sync_n_i,
  input  wire logic              sclk_i,
  input  wire logic              din_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic      [CODE_W-1:0] channel_a_output_o,
  output logic      [CODE_W-1:0] channel_b_output_o,
  output logic      [1:0]        pd_term_o
);
  localparam int LVL_W = $clog2(DEPTH + 1);

  // mode field decode, used by buffer drain and checks
  function automatic logic [1:0] frame_mode(input logic [FRAME_W-1:0] w);
    frame_mode = w[MODE_HI:MODE_LO];
  endfunction : frame_mode

  // ---------------- pin synchronisers ----------------
  logic [1:0] sync_meta_ff;
  logic [1:0] sync_s_ff;
  logic       sclk_meta_ff;
  logic       sclk_s_ff;
  logic       sclk_d_ff;
  logic       din_meta_ff;
  logic       din_s_ff;

  // two flops on din, four on the strobe; sclk gets a third stage only for edge finding
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync_meta_ff <= 2'h3;
      sync_s_ff    <= 2'h3;
      sclk_meta_ff <= 1'b1;
      sclk_s_ff    <= 1'b1;
      sclk_d_ff    <= 1'b1;
      din_meta_ff  <= 1'b0;
      din_s_ff     <= 1'b0;
    end else begin
      sync_meta_ff <= {sync_meta_ff[0], sync_n_i};
      sync_s_ff    <= {sync_s_ff[0], sync_meta_ff[1]};
      sclk_meta_ff <= sclk_i;
      sclk_s_ff    <= sclk_meta_ff;
      sclk_d_ff    <= sclk_s_ff;
      din_meta_ff  <= din_i;
      din_s_ff     <= din_meta_ff;
    end
  end

  wire sync_s    = sync_s_ff[1];
  wire sclk_fall = sclk_d_ff & ~sclk_s_ff;

  // ---------------- control registers ----------------
  logic [1:0]  ctrl_ff;
  logic        ovr_ff;
  logic [15:0] frames_ff;
  logic [15:0] aborts_ff;
  wire         rx_enable = ctrl_ff[CTRL_EN_BIT];
  wire         hold      = ctrl_ff[CTRL_HOLD_BIT];

  // ---------------- frame receiver ----------------
  ddsl_link_t         state_ff;
  ddsl_link_t         nxt_state;
  logic [4:0]         bit_cnt_ff;
  logic [FRAME_W-1:0] shift_ff;
  logic               push_valid_ff;
  logic [FRAME_W-1:0] push_data_ff;

  ddsl_fifo_if #(.WIDTH(FRAME_W), .LVL_W(LVL_W)) fifo_if ();

  wire take_bit  = (state_ff == LK_SHIFT) & ~sync_s & sclk_fall;
  wire last_bit  = take_bit & (bit_cnt_ff == CNT_LAST);
  wire abort_now = (state_ff == LK_SHIFT) & sync_s;
  wire [FRAME_W-1:0] nxt_shift = {shift_ff[FRAME_W-2:0], din_s_ff};

  // strobe fall opens a frame; rise before the count ends aborts it
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LK_IDLE: begin
        if (!sync_s && rx_enable) begin
          nxt_state = LK_SHIFT;
        end
      end
      LK_SHIFT: begin
        if (abort_now) begin
          nxt_state = LK_IDLE;
        end else if (last_bit) begin
          nxt_state = LK_FULL;
        end
      end
      LK_FULL: begin
        if (sync_s) begin
          nxt_state = LK_IDLE;
        end
      end
      default: nxt_state = LK_IDLE;
    endcase
  end

  // extra edges after the sixteenth are ignored until the strobe rises
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_ff   <= LK_IDLE;
      bit_cnt_ff <= CNT_ZERO;
      shift_ff   <= '0;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= (state_ff != LK_SHIFT) ? CNT_ZERO :
                    take_bit ? bit_cnt_ff + CNT_ONE : bit_cnt_ff;
      shift_ff   <= take_bit ? nxt_shift : shift_ff;
    end
  end

  // completed word is handed to the buffer as a one-cycle push
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      push_valid_ff <= 1'b0;
      push_data_ff  <= '0;
    end else begin
      push_valid_ff <= last_bit;
      push_data_ff  <= last_bit ? nxt_shift : push_data_ff;
    end
  end

  assign fifo_if.push_valid = push_valid_ff;
  assign fifo_if.push_data  = push_data_ff;
  // holding the drain lets software batch frames; release applies them one per cycle
  assign fifo_if.pop_ready  = ~hold;

  ddsl_fifo #(
    .WIDTH (FRAME_W),
    .DEPTH (DEPTH),
    .LVL_W (LVL_W)
  ) i_ddsl_fifo (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .f      (fifo_if.buf_side)
  );

  // ---------------- frame apply ----------------
  wire               pop_fire = fifo_if.pop_valid & fifo_if.pop_ready;
  wire [FRAME_W-1:0] pw       = fifo_if.pop_data;
  wire [1:0]         pmode    = frame_mode(pw);
  wire               is_pd    = pop_fire & (pmode == MODE_PD);
  wire               is_wr    = pop_fire &
                                ((pmode == MODE_ONE) | (pmode == MODE_BOTH));
  wire               overrun  = push_valid_ff & ~fifo_if.push_ready;

  logic [CODE_W-1:0] code_ff [NUM_CH];
  logic [CODE_W-1:0] out_ff  [NUM_CH];
  logic [1:0]        pd_term_ff;

  // one code register and one output stage per channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      wire hit = is_wr & ((pmode == MODE_BOTH) |
                          (pw[SEL_BIT] == 1'(ch)));
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          code_ff[ch] <= '0;
          out_ff[ch]  <= '0;
        end else begin
          code_ff[ch] <= hit ? pw[CODE_W-1:0] : code_ff[ch];
          out_ff[ch]  <= (pd_term_ff != TERM_AWAKE) ? '0 : code_ff[ch];
        end
      end
    end
  endgenerate

  // a write wakes the device; mode three is not acted upon
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pd_term_ff <= TERM_AWAKE;
    end else if (is_pd) begin
      pd_term_ff <= pw[TERM_HI:TERM_LO];
    end else if (is_wr) begin
      pd_term_ff <= TERM_AWAKE;
    end
  end

  assign channel_a_output_o = out_ff[0];
  assign channel_b_output_o = out_ff[1];
  assign pd_term_o          = pd_term_ff;

  // ---------------- register bus slave ----------------
  logic        ack_ff;
  logic        waitreq_ff;
  logic [31:0] rdata_ff;
  wire         req     = avs_read_i | avs_write_i;
  wire         nxt_ack = req & ~ack_ff;
  wire         wr_fire = avs_write_i & ack_ff;
  wire         be0     = avs_byteenable_i[0];
  wire         wr_ctrl = wr_fire & be0 & (avs_address_i == OFS_CTRL);
  wire         wr_stat = wr_fire & be0 & (avs_address_i == OFS_STAT);
  wire         ovr_clr = wr_stat & avs_writedata_i[STAT_OVR_BIT];
  wire [31:0]  stat_w  = {26'h0, ovr_ff, (pd_term_ff != TERM_AWAKE),
                          4'(fifo_if.level)};
  wire [31:0]  codes_w = {4'h0, code_ff[1], 4'h0, code_ff[0]};
  wire [31:0]  rd_mux  =
    (avs_address_i == OFS_CTRL)  ? {30'h0, ctrl_ff} :
    (avs_address_i == OFS_STAT)  ? stat_w :
    (avs_address_i == OFS_CODES) ? codes_w :
    (avs_address_i == OFS_FRMS)  ? {16'h0, frames_ff} :
    (avs_address_i == OFS_ABRT)  ? {16'h0, aborts_ff} : 32'h0;

  // fixed one wait state; unmapped reads give zero, writes are dropped
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ack_ff     <= 1'b0;
      waitreq_ff <= 1'b1;
      rdata_ff   <= 32'h0;
    end else begin
      ack_ff     <= nxt_ack;
      waitreq_ff <= ~nxt_ack;
      rdata_ff   <= (nxt_ack & avs_read_i) ? rd_mux : rdata_ff;
    end
  end

  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = waitreq_ff;

  // overrun set beats a same-cycle clear so no loss goes unseen
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_ff   <= CTRL_RST;
      ovr_ff    <= 1'b0;
      frames_ff <= '0;
      aborts_ff <= '0;
    end else begin
      ctrl_ff   <= wr_ctrl ? avs_writedata_i[1:0] : ctrl_ff;
      ovr_ff    <= overrun | (ovr_ff & ~ovr_clr);
      frames_ff <= pop_fire ? frames_ff + CNT16_ONE : frames_ff;
      aborts_ff <= abort_now ? aborts_ff + CNT16_ONE : aborts_ff;
    end
  end

  // ---------------- checks ----------------
  logic seen_wr_ff;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      seen_wr_ff <= 1'b0;
    end else begin
      seen_wr_ff <= seen_wr_ff | is_wr;
    end
  end

  property p_bit_capture;
    @(posedge mclk_i) disable iff (!rstn_i)
      take_bit |=> shift_ff[0] == $past(din_s_ff);
  endproperty
  a_bit_capture: assert property (p_bit_capture)
    else $error("serial bit not captured on falling edge");

  property p_shift_low_only;
    @(posedge mclk_i) disable iff (!rstn_i)
      (shift_ff != $past(shift_ff)) |-> !$past(sync_s, 1);
  endproperty
  a_shift_low_only: assert property (p_shift_low_only)
    else $error("shift register moved while strobe high");

  property p_push_on_16th;
    @(posedge mclk_i) disable iff (!rstn_i)
      last_bit |=> push_valid_ff ##1 !push_valid_ff;
  endproperty
  a_push_on_16th: assert property (p_push_on_16th)
    else $error("frame not pushed at sixteenth edge");

  property p_abort;
    @(posedge mclk_i) disable iff (!rstn_i)
      abort_now |=> !push_valid_ff && state_ff == LK_IDLE &&
                    aborts_ff == $past(aborts_ff) + CNT16_ONE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("aborted frame was not discarded");

  property p_both_equal;
    @(posedge mclk_i) disable iff (!rstn_i)
      (pop_fire && pmode == MODE_BOTH) |=> code_ff[0] == code_ff[1];
  endproperty
  a_both_equal: assert property (p_both_equal)
    else $error("joint update left channels different");

  property p_single_keeps_other;
    @(posedge mclk_i) disable iff (!rstn_i)
      (pop_fire && pmode == MODE_ONE && !pw[SEL_BIT])
        |=> $stable(code_ff[1]);
  endproperty
  a_single_keeps_other: assert property (p_single_keeps_other)
    else $error("write to channel a disturbed channel b");

  property p_zero_until_write;
    @(posedge mclk_i) disable iff (!rstn_i)
      !seen_wr_ff |-> ##1 (out_ff[0] == '0 && out_ff[1] == '0);
  endproperty
  a_zero_until_write: assert property (p_zero_until_write)
    else $error("output nonzero before first write");

  property p_pd_zero;
    @(posedge mclk_i) disable iff (!rstn_i)
      is_pd && pw[TERM_HI:TERM_LO] != TERM_AWAKE
        |=> ##1 out_ff[0] == '0 && pd_term_ff == $past(pw[TERM_HI:TERM_LO], 2);
  endproperty
  a_pd_zero: assert property (p_pd_zero)
    else $error("power-down frame not applied");

  property p_code_only_on_write;
    @(posedge mclk_i) disable iff (!rstn_i)
      (code_ff[0] != $past(code_ff[0])) |-> $past(is_wr);
  endproperty
  a_code_only_on_write: assert property (p_code_only_on_write)
    else $error("channel code changed without a write");

  property p_msb_first;
    @(posedge mclk_i) disable iff (!rstn_i)
      last_bit |=> push_data_ff[FRAME_W-1] == $past(shift_ff[FRAME_W-2]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first bit did not land at the top");
endmodule : ddsl_top

// *** sim/ddsl_host.sv ***
// host side model: drives strobe, serial clock and data of the link
`timescale 1ns/1ps
module ddsl_host (
  input  wire logic mclk_i,
  output logic      sync_n_o,
  output logic      sclk_o,
  output logic      din_o
);
  // idle: strobe high, clock parked high so no stray fall is seen
  initial begin
    sync_n_o = 1'b1;
    sclk_o   = 1'b1;
    din_o    = 1'b0;
  end

  // one frame of nb bits, half period 16 mclk (160 ns link clock);
  // nb below 16 aborts the frame
  task automatic send(input logic [15:0] w, input int nb);
    int i;
    @(posedge mclk_i);
    sync_n_o <= 1'b0;
    repeat (16) @(posedge mclk_i);
    for (i = 0; i < nb; i++) begin
      din_o <= w[15-i];
      repeat (16) @(posedge mclk_i);
      sclk_o <= 1'b0;
      repeat (16) @(posedge mclk_i);
      sclk_o <= 1'b1;
    end
    // flip the last bit so a stale level is never taken for data
    sync_n_o <= 1'b1;
    din_o    <= ~din_o;
    repeat (80) @(posedge mclk_i);
  endtask : send
endmodule : ddsl_host

// *** sim/dual_dac_serial_load_bench.sv ***
// self-checking bench of the serial load block against a queue model
`timescale 1ns/1ps
module dual_dac_serial_load_bench;
  import ddsl_pkg::*;
  logic        mclk_i           = 1'b0;
  logic        rstn_i           = 1'b0;
  logic        sync_n_i;
  logic        sclk_i;
  logic        din_i;
  logic [4:0]  avs_address_i    = 5'h00;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [11:0] channel_a_output_o;
  logic [11:0] channel_b_output_o;
  logic [1:0]  pd_term_o;
  int          n_mismatch, samples_checked, cyc, i;
  int          ca, cb, term, nfrm, nabrt, en = 1, held, ovr;
  logic [15:0] q[$];
  logic [31:0] rng = 32'h26E9;
  logic [15:0] w;
  logic [31:0] rsp;

  always #2.5 mclk_i = ~mclk_i;

  ddsl_top #(.DEPTH(8)) i_ddsl_top (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .sync_n_i(sync_n_i),
    .sclk_i(sclk_i), .din_i(din_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .channel_a_output_o(channel_a_output_o),
    .channel_b_output_o(channel_b_output_o), .pd_term_o(pd_term_o));

  ddsl_host i_ddsl_host (.mclk_i(mclk_i), .sync_n_o(sync_n_i),
                         .sclk_o(sclk_i), .din_o(din_i));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic stop_test;
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // one Avalon cycle: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] r);
    @(posedge mclk_i);
    avs_address_i    <= a;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    avs_read_i       <= !wr;
    avs_write_i      <= wr;
    // only the bench timeout ends a wait that never comes
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hF, r);
    chk(r, e);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'hF, r);
  endtask : wr

  // model of a completed frame
  task automatic apply(input logic [15:0] f);
    nfrm++;
    case (f[15:14])
      2'h0: begin
        if (f[12]) cb = f[11:0];
        else ca = f[11:0];
        term = 0;
      end
      2'h1: begin
        ca   = f[11:0];
        cb   = f[11:0];
        term = 0;
      end
      2'h2: term = f[13:12];
      default: ;
    endcase
  endtask : apply

  // compare ports and registers with the model
  task automatic check_all;
    repeat (20) @(posedge mclk_i);
    chk(channel_a_output_o, term != 0 ? 0 : ca);
    chk(channel_b_output_o, term != 0 ? 0 : cb);
    chk(pd_term_o, term);
    rd(OFS_CODES, (cb << 16) | ca);
    rd(OFS_FRMS, nfrm);
    rd(OFS_ABRT, nabrt);
    rd(OFS_STAT, (ovr << 5) | ((term != 0) << 4) | q.size());
  endtask : check_all

  task automatic frame(input logic [15:0] f, input int nb);
    i_ddsl_host.send(f, nb);
    if (en == 0) ;
    else if (nb < 16) nabrt++;
    else if (held == 0) apply(f);
    else if (q.size() < 8) q.push_back(f);
    else ovr = 1;
    check_all;
  endtask : frame

  // hang guard: the planned run needs about 31k cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      stop_test;
    end
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(OFS_CTRL, 32'h1);
    rd(5'h14, 32'h0);
    wr(5'h14, 32'hFFFF_FFFF);
    bus(1'b1, OFS_CTRL, 32'h0, 4'hE, rsp);
    rd(OFS_CTRL, 32'h1);
    check_all;
    // every mode and select/termination pair, then random with aborts
    for (i = 0; i < 40; i++) begin
      rng = xs(rng);
      w = rng[15:0];
      if (i < 16) w[15:12] = i[3:0];
      frame(w, (i >= 16 && rng[17:16] == 2'h0) ? 1 + rng[20:18] * 2 : 16);
    end
    // buffer fills while drain is held, ninth frame overruns
    wr(OFS_CTRL, 32'h3);
    held = 1;
    for (i = 0; i < 9; i++) begin
      rng = xs(rng);
      frame({2'h1, rng[13:0]}, 16);
    end
    wr(OFS_CTRL, 32'h1);
    held = 0;
    while (q.size() > 0) apply(q.pop_front());
    check_all;
    wr(OFS_STAT, 32'h20);
    ovr = 0;
    check_all;
    // receiver disabled: a full frame leaves everything alone
    wr(OFS_CTRL, 32'h0);
    en = 0;
    frame(16'h4ABC, 16);
    wr(OFS_CTRL, 32'h1);
    en = 1;
    frame(16'h4123, 16);
    stop_test;
  end
endmodule : dual_dac_serial_load_bench
